//--- src/motor_spi_slave.sv
// serial slave port of the stepper driver with register file, sleep gating and hard reset
`timescale 1ns/1ns
module motor_spi_slave (
  // system clock, reset, freeze
  input wire logic clock_i,
  input wire logic rst_n_i,
  input wire logic ce_i,
  // hard reset pin, active high
  input wire logic hard_reset_input_i,
  // serial link from the master
  input wire logic sclk_i,
  input wire logic cs_n_i,
  input wire logic serial_in_pin_i,
  // open-drain serial output
  output logic data_out_o,
  output logic data_out_oe_n_o,
  // step and direction pins
  input wire logic step_pulse_input_i,
  input wire logic direction_input_i,
  output logic step_pulse_o,
  output logic direction_o,
  // status event sources, one bit per flag
  input wire logic [6:0] stat0_evt_i,
  input wire logic [6:0] stat1_evt_i,
  input wire logic [6:0] stat2_evt_i,
  input wire logic [6:0] stat3_evt_i,
  // control register contents
  output logic [7:0] ctrl_wd_o,
  output logic [7:0] ctrl0_o,
  output logic [7:0] ctrl1_o,
  output logic [7:0] ctrl2_o,
  // power state and housekeeping
  output logic sleep_o,
  output logic drivers_hiz_o,
  output logic analog_enable_o,
  output logic clock_run_o,
  output logic watchdog_clear_o,
  output logic reset_watchdog_output_o,
  output logic error_n_o
);

  ////////////////////////////////////////////////////////////////////////////
  // declarations

  logic [7:0] ctrl [motor_spi_pkg::CTRL_COUNT];
  logic [6:0] stat [motor_spi_pkg::STAT_COUNT];
  logic [6:0] evt [motor_spi_pkg::STAT_COUNT];

  logic spi_rst_n;
  logic [2:0] bit_idx;
  logic [1:0] byte_cnt;
  logic expect_data;
  logic [6:0] shift_in;
  logic [7:0] rx_byte;
  logic [4:0] pointer;
  logic [4:0] wr_addr;
  logic [7:0] wr_data;
  logic wr_first;
  logic len_ok;
  logic [3:0] rd_mask;
  logic frame_tog;
  logic frame_start;
  logic byte_end;
  logic [7:0] out_shift;
  logic [7:0] read_value;

  logic cs_meta;
  logic cs_high;
  logic tog_meta;
  logic tog_sync;
  logic tog_seen;
  logic hr_meta;
  logic hr_sync;
  logic hr_active;
  logic commit;
  logic step_meta;
  logic step_sync;
  logic dir_meta;
  logic dir_sync;
  logic sleep;

  assign evt[0] = stat0_evt_i;
  assign evt[1] = stat1_evt_i;
  assign evt[2] = stat2_evt_i;
  assign evt[3] = stat3_evt_i;

  ////////////////////////////////////////////////////////////////////////////
  // link domain, receive side on the rising serial clock

  assign spi_rst_n = rst_n_i & ~cs_n_i;
  assign frame_start = (byte_cnt == motor_spi_pkg::BYTE_FIRST) && (bit_idx == 3'h0);
  assign byte_end = (bit_idx == motor_spi_pkg::BIT_LAST);
  assign rx_byte = {shift_in, serial_in_pin_i};

  always_ff @(posedge sclk_i or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      bit_idx <= 3'h0;
      byte_cnt <= motor_spi_pkg::BYTE_FIRST;
    end else begin
      bit_idx <= bit_idx + 3'h1;
      if (byte_end && byte_cnt != motor_spi_pkg::BYTE_BEYOND) begin
        byte_cnt <= byte_cnt + 2'h1;
      end
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      shift_in <= 7'h00;
    end else begin
      shift_in <= rx_byte[6:0];
    end
  end

  always_ff @(posedge sclk_i or negedge spi_rst_n) begin
    if (!spi_rst_n) begin
      expect_data <= 1'b0;
    end else if (byte_end) begin
      expect_data <= !expect_data &&
        (rx_byte[motor_spi_pkg::CMD_MSB:motor_spi_pkg::CMD_LSB] == motor_spi_pkg::CMD_WRITE);
    end
  end

  // pointer survives between packets so the next packet's first byte returns it
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pointer <= motor_spi_pkg::ADDR_CTRL_WD;
    end else if (byte_end && !expect_data) begin
      pointer <= rx_byte[motor_spi_pkg::PTR_MSB:0];
    end
  end

  // write request of the first two bytes
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      wr_first <= 1'b0;
      wr_addr <= motor_spi_pkg::ADDR_CTRL_WD;
      wr_data <= motor_spi_pkg::CTRL_RESET;
    end else if (frame_start) begin
      wr_first <= 1'b0;
    end else if (byte_end && byte_cnt == motor_spi_pkg::BYTE_FIRST) begin
      wr_first <= rx_byte[motor_spi_pkg::CMD_MSB:motor_spi_pkg::CMD_LSB] ==
        motor_spi_pkg::CMD_WRITE;
      wr_addr <= rx_byte[motor_spi_pkg::PTR_MSB:0];
    end else if (byte_end && byte_cnt == motor_spi_pkg::BYTE_SECOND) begin
      wr_data <= rx_byte;
    end
  end

  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      len_ok <= 1'b0;
    end else if (frame_start || byte_cnt == motor_spi_pkg::BYTE_BEYOND) begin
      len_ok <= 1'b0;
    end else if (byte_end && byte_cnt == motor_spi_pkg::BYTE_SECOND) begin
      len_ok <= wr_first;
    end
  end

  // remember which status registers were read in this packet
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rd_mask <= 4'h0;
    end else if (frame_start) begin
      rd_mask <= 4'h0;
    end else if (byte_end && !expect_data &&
                 rx_byte[motor_spi_pkg::CMD_MSB:motor_spi_pkg::CMD_LSB] ==
                 motor_spi_pkg::CMD_READ &&
                 rx_byte[motor_spi_pkg::PTR_MSB:0] >= motor_spi_pkg::ADDR_STAT0 &&
                 rx_byte[motor_spi_pkg::PTR_MSB:0] <= motor_spi_pkg::ADDR_STAT3) begin
      rd_mask[rx_byte[1:0]] <= 1'b1;
    end
  end

  // one toggle per packet that clocked, so an empty packet commits nothing twice
  always_ff @(posedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      frame_tog <= 1'b0;
    end else if (frame_start) begin
      frame_tog <= ~frame_tog;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // link domain, transmit side on the falling serial clock

  // registers are frozen while selected, except under hard reset, so the link clock may read them directly
  always_comb begin
    read_value = 8'h00;
    if (pointer < motor_spi_pkg::ADDR_STAT0) begin
      read_value = ctrl[pointer[1:0]];
    end else if (pointer <= motor_spi_pkg::ADDR_STAT3) begin
      read_value = {^stat[pointer[1:0]], stat[pointer[1:0]]};
    end
  end

  always_ff @(negedge sclk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      out_shift <= 8'hFF;
    end else if (bit_idx == 3'h0 && !cs_n_i) begin
      out_shift <= read_value;
    end else begin
      out_shift <= {out_shift[6:0], 1'b1};
    end
  end

  // output driven only when the master selects the port
  assign data_out_o = 1'b0;
  assign data_out_oe_n_o = cs_n_i | out_shift[motor_spi_pkg::PARITY_BIT];

  ////////////////////////////////////////////////////////////////////////////
  // system domain synchronisers

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      // idle level of the deselected pin, so no false select follows reset
      cs_meta <= 1'b1;
      cs_high <= 1'b1;
      tog_meta <= 1'b0;
      tog_sync <= 1'b0;
      hr_meta <= 1'b0;
      hr_sync <= 1'b0;
      step_meta <= 1'b0;
      step_sync <= 1'b0;
      dir_meta <= 1'b0;
      dir_sync <= 1'b0;
    end else if (ce_i) begin
      cs_meta <= cs_n_i;
      cs_high <= cs_meta;
      tog_meta <= frame_tog;
      tog_sync <= tog_meta;
      hr_meta <= hard_reset_input_i;
      hr_sync <= hr_meta;
      step_meta <= step_pulse_input_i;
      step_sync <= step_meta;
      dir_meta <= direction_input_i;
      dir_sync <= dir_meta;
    end
  end

  assign sleep = ctrl[motor_spi_pkg::ADDR_CTRL2[1:0]][motor_spi_pkg::SLEEP_BIT];
  // hard reset held while pin high, ignored in sleep
  assign hr_active = hr_sync && !sleep;
  assign commit = cs_high && (tog_sync != tog_seen);

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      tog_seen <= 1'b0;
    end else if (ce_i && commit) begin
      tog_seen <= tog_sync;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register file

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < motor_spi_pkg::CTRL_COUNT; i++) begin
        ctrl[i] <= motor_spi_pkg::CTRL_RESET;
      end
    end else if (ce_i) begin
      if (hr_active) begin
        for (int i = 0; i < motor_spi_pkg::CTRL_COUNT; i++) begin
          ctrl[i] <= motor_spi_pkg::CTRL_RESET;
        end
      end else if (commit && len_ok && wr_addr < motor_spi_pkg::ADDR_STAT0) begin
        // sleep bit set and cleared here
        ctrl[wr_addr[1:0]] <= wr_data;
      end
    end
  end

  // flags latch and clear only while deselected, but hard reset clears them at any time outside sleep; a new event wins over clear
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < motor_spi_pkg::STAT_COUNT; i++) begin
        stat[i] <= motor_spi_pkg::STAT_RESET;
      end
    end else if (ce_i) begin
      for (int i = 0; i < motor_spi_pkg::STAT_COUNT; i++) begin
        if (hr_active) begin
          stat[i] <= motor_spi_pkg::STAT_RESET;
        end else if (cs_high) begin
          stat[i] <= (commit && rd_mask[i]) ? evt[i] : (stat[i] | evt[i]);
        end
      end
    end
  end

  // fault output follows flags while deselected
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      error_n_o <= 1'b1;
    end else if (ce_i && cs_high) begin
      error_n_o <= !(|stat[0] || |stat[1] || |stat[2] || |stat[3]);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sleep gating and housekeeping outputs

  // step and direction ignored in sleep
  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      step_pulse_o <= 1'b0;
      direction_o <= 1'b0;
    end else if (ce_i && !sleep) begin
      step_pulse_o <= step_sync;
      direction_o <= dir_sync;
    end
  end

  always_ff @(posedge clock_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      watchdog_clear_o <= 1'b0;
    end else if (ce_i) begin
      watchdog_clear_o <= hr_active;
    end
  end

  assign ctrl_wd_o = ctrl[0];
  assign ctrl0_o = ctrl[1];
  assign ctrl1_o = ctrl[2];
  assign ctrl2_o = ctrl[3];
  // drivers idle, analog off in sleep
  assign sleep_o = sleep;
  assign drivers_hiz_o = sleep;
  assign analog_enable_o = !sleep;
  // clocks run in sleep only while selected; the serial side needs none
  assign clock_run_o = !sleep || !cs_high;
  // hard reset leaves the reset pin released (active low)
  assign reset_watchdog_output_o = 1'b1;

endmodule

//--- src/motor_spi_pkg.sv
// constants of the stepper driver serial slave port, sleep gating and hard reset
package motor_spi_pkg;

  // command field of the first byte
  localparam logic [2:0] CMD_READ = 3'h0;
  localparam logic [2:0] CMD_WRITE = 3'h4;
  localparam int CMD_MSB = 7;
  localparam int CMD_LSB = 5;
  localparam int PTR_MSB = 4;

  // register pointers
  localparam logic [4:0] ADDR_CTRL_WD = 5'h00;
  localparam logic [4:0] ADDR_CTRL0 = 5'h01;
  localparam logic [4:0] ADDR_CTRL1 = 5'h02;
  localparam logic [4:0] ADDR_CTRL2 = 5'h03;
  localparam logic [4:0] ADDR_STAT0 = 5'h04;
  localparam logic [4:0] ADDR_STAT3 = 5'h07;
  localparam int CTRL_COUNT = 4;
  localparam int STAT_COUNT = 4;
  localparam int STAT_WIDTH = 7;

  // field positions and reset values
  localparam int SLEEP_BIT = 6;
  localparam int PARITY_BIT = 7;
  localparam logic [7:0] CTRL_RESET = 8'h00;
  localparam logic [6:0] STAT_RESET = 7'h00;

  // bit and byte counting of a packet
  localparam logic [2:0] BIT_LAST = 3'h7;
  localparam logic [1:0] BYTE_FIRST = 2'h0;
  localparam logic [1:0] BYTE_SECOND = 2'h1;
  localparam logic [1:0] BYTE_BEYOND = 2'h2;

  // least hard reset pulse kept by the master, and its length in system clocks
  localparam int CLOCK_HZ = 20_000_000;
  localparam int HARD_RESET_MIN_PULSE_NS = 1000;
  localparam int HARD_RESET_MIN_CYCLES =
    (HARD_RESET_MIN_PULSE_NS * (CLOCK_HZ / 1_000_000) + 999) / 1000;

endpackage

//--- verification/motor_spi_checker_assertions.sv
// concurrent checks on the pins of the serial slave port
`timescale 1ns/1ns
module motor_spi_checker (
  // clock and reset
  input wire logic clock_i,
  input wire logic rst_n_i,
  // pins driven by the master and the board
  input wire logic cs_n_i,
  input wire logic hard_reset_input_i,
  // pins driven by the port
  input wire logic data_out_o,
  input wire logic data_out_oe_n_o,
  input wire logic step_pulse_o,
  input wire logic direction_o,
  input wire logic [7:0] ctrl_wd_o,
  input wire logic [7:0] ctrl0_o,
  input wire logic [7:0] ctrl1_o,
  input wire logic [7:0] ctrl2_o,
  input wire logic sleep_o,
  input wire logic drivers_hiz_o,
  input wire logic analog_enable_o,
  input wire logic clock_run_o,
  input wire logic watchdog_clear_o,
  input wire logic reset_watchdog_output_o,
  input wire logic error_n_o
);
  default clocking cb @(posedge clock_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////
  oe_release_a: assert property (cs_n_i |-> data_out_oe_n_o && !data_out_o)
    else $error("data out held while deselected");
  sleep_state_a: assert property (sleep_o == ctrl2_o[6] && drivers_hiz_o == sleep_o
    && analog_enable_o == !sleep_o)
    else $error("sleep outputs disagree with control bit");
  step_freeze_a: assert property (sleep_o && $past(sleep_o)
    |-> $stable(step_pulse_o) && $stable(direction_o))
    else $error("step or direction moved in sleep");
  run_awake_a: assert property (!sleep_o |-> clock_run_o)
    else $error("clocks stopped while awake");
  run_select_a: assert property ($fell(cs_n_i) |-> ##[0:3] clock_run_o)
    else $error("clocks not started for serial access");
  run_idle_a: assert property ((sleep_o && cs_n_i)[*4] |-> !clock_run_o)
    else $error("clocks running in idle sleep");
  hard_clear_a: assert property ((hard_reset_input_i && !sleep_o)[*4]
    |=> {ctrl_wd_o, ctrl0_o, ctrl1_o, ctrl2_o} == 32'h00000000)
    else $error("hard reset left control bits set");
  wd_reset_a: assert property ((hard_reset_input_i && !sleep_o)[*5]
    |-> watchdog_clear_o && reset_watchdog_output_o)
    else $error("watchdog not cleared or reset output asserted");
  err_frozen_a: assert property ((!cs_n_i)[*6] |-> $stable(error_n_o))
    else $error("error output moved while selected");
  ctrl_frozen_a: assert property ((!cs_n_i && !hard_reset_input_i)[*6]
    |-> $stable({ctrl_wd_o, ctrl0_o, ctrl1_o, ctrl2_o}))
    else $error("control changed before deselect");
  cover property ($rose(sleep_o));
  cover property ($fell(error_n_o));
  cover property ($rose(watchdog_clear_o));
endmodule

bind motor_spi_slave motor_spi_checker i_motor_spi_checker (.clock_i(clock_i),
  .rst_n_i(rst_n_i), .cs_n_i(cs_n_i), .hard_reset_input_i(hard_reset_input_i),
  .data_out_o(data_out_o), .data_out_oe_n_o(data_out_oe_n_o), .step_pulse_o(step_pulse_o),
  .direction_o(direction_o), .ctrl_wd_o(ctrl_wd_o), .ctrl0_o(ctrl0_o), .ctrl1_o(ctrl1_o),
  .ctrl2_o(ctrl2_o), .sleep_o(sleep_o), .drivers_hiz_o(drivers_hiz_o),
  .analog_enable_o(analog_enable_o), .clock_run_o(clock_run_o),
  .watchdog_clear_o(watchdog_clear_o), .reset_watchdog_output_o(reset_watchdog_output_o),
  .error_n_o(error_n_o));

//--- verification/spi_master_model.sv
// mode 0 serial master driving the slave port
`timescale 1ns/1ns
module spi_master_model (
  // serial link
  output logic sclk_o,
  output logic cs_n_o,
  output logic mosi_o,
  input wire logic miso_i
);
  initial begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    mosi_o = 1'b1;
  end
  ////////////////////////////////////////////////////////////////
  // clock idles low, msb first
  // select always raised after each packet, idle high
  task automatic xfer(input logic [23:0] tx, input int nbits, output logic [23:0] rx);
    rx = 24'h000000;
    #7 cs_n_o = 1'b0;
    #200;
    for (int i = nbits - 1; i >= 0; i--) begin
      mosi_o = tx[i];
      #16 sclk_o = 1'b1;
      rx = {rx[22:0], miso_i};
      #16 sclk_o = 1'b0;
    end
    // released data line shows the inverse of its last bit
    #16 mosi_o = ~mosi_o;
    cs_n_o = 1'b1;
    #300;
  endtask
endmodule

//--- verification/tb_top.sv
// self-checking bench of the serial slave port
`timescale 1ns/1ns
module tb_top;
  logic clock_i, rst_n_i, hard_reset_input_i, sclk, cs_n, mosi, miso, step_i, dir_i;
  logic data_out_o, data_out_oe_n_o, step_pulse_o, direction_o, sleep_o, drivers_hiz_o;
  logic analog_enable_o, clock_run_o, watchdog_clear_o, reset_watchdog_output_o, error_n_o;
  logic [7:0] ctrl_wd_o, ctrl0_o, ctrl1_o, ctrl2_o, d;
  logic [6:0] stat1_evt;
  logic [23:0] rx;
  int err_total, n_tests;
  // pull-up on the open-drain line
  assign miso = data_out_oe_n_o ? 1'b1 : data_out_o;
  motor_spi_slave i_motor_spi_slave (.clock_i(clock_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .hard_reset_input_i(hard_reset_input_i), .sclk_i(sclk), .cs_n_i(cs_n),
    .serial_in_pin_i(mosi), .data_out_o(data_out_o), .data_out_oe_n_o(data_out_oe_n_o),
    .step_pulse_input_i(step_i), .direction_input_i(dir_i), .step_pulse_o(step_pulse_o),
    .direction_o(direction_o), .stat0_evt_i(7'h00), .stat1_evt_i(stat1_evt),
    .stat2_evt_i(7'h00), .stat3_evt_i(7'h00), .ctrl_wd_o(ctrl_wd_o), .ctrl0_o(ctrl0_o),
    .ctrl1_o(ctrl1_o), .ctrl2_o(ctrl2_o), .sleep_o(sleep_o), .drivers_hiz_o(drivers_hiz_o),
    .analog_enable_o(analog_enable_o), .clock_run_o(clock_run_o),
    .watchdog_clear_o(watchdog_clear_o), .reset_watchdog_output_o(reset_watchdog_output_o),
    .error_n_o(error_n_o));
  spi_master_model i_spi_master_model (.sclk_o(sclk), .cs_n_o(cs_n), .mosi_o(mosi),
    .miso_i(miso));
  ////////////////////////////////////////////////////////////////
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_total++;
      $display("ERROR %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic give_verdict();
    $display("checks %0d errors %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic rd(input logic [4:0] a);
    i_spi_master_model.xfer({8'h00, motor_spi_pkg::CMD_READ, a, 8'h00}, 16, rx);
    d = rx[7:0];
    // realign to the falling edge so the next stimulus keeps that timing
    @(negedge clock_i);
  endtask
  task automatic wr(input logic [4:0] a, input logic [7:0] v);
    i_spi_master_model.xfer({8'h00, motor_spi_pkg::CMD_WRITE, a, v}, 16, rx);
    @(negedge clock_i);
  endtask
  task automatic cycles(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  ////////////////////////////////////////////////////////////////
  task automatic t_write_read();
    for (int a = 0; a < 4; a++) begin
      rd(a[4:0]);
      check(d, 8'h00);
      wr(a[4:0], 8'h90 | a[7:0]);
      check(rx[7:0], 8'h00);
      rd(a[4:0]);
      check(rx[15:0], {8'h00, 8'h90 | a[7:0]});
    end
    check({ctrl2_o, ctrl1_o, ctrl0_o, ctrl_wd_o}, 32'h93929190);
  endtask
  task automatic t_refused();
    i_spi_master_model.xfer({9'h000, 3'h4, 5'h02, 7'h1E}, 15, rx);
    i_spi_master_model.xfer({7'h00, 3'h4, 5'h02, 8'h3C, 1'b0}, 17, rx);
    check(ctrl1_o, 8'h92);
    wr(motor_spi_pkg::ADDR_STAT0, 8'h7F);
    rd(motor_spi_pkg::ADDR_STAT0);
    check(d, 8'h00);
    check({ctrl2_o, ctrl1_o, ctrl0_o, ctrl_wd_o}, 32'h93929190);
  endtask
  task automatic t_status();
    logic [6:0] ev[2] = '{7'h0B, 7'h03};
    for (int i = 0; i < 2; i++) begin
      stat1_evt = ev[i];
      cycles(4);
      stat1_evt = 7'h00;
      cycles(3);
      check(error_n_o, 1'b0);
      rd(5'h05);
      check(d, {^ev[i], ev[i]});
      check(error_n_o, 1'b1);
      rd(5'h05);
      check(d, 8'h00);
    end
  endtask
  task automatic t_sleep();
    wr(motor_spi_pkg::ADDR_CTRL2, 8'h40);
    check({sleep_o, drivers_hiz_o, analog_enable_o, clock_run_o}, 4'hC);
    step_i = 1'b1;
    dir_i = 1'b1;
    cycles(6);
    check({step_pulse_o, direction_o}, 2'h0);
    // pin held for the least pulse
    hard_reset_input_i = 1'b1;
    cycles(motor_spi_pkg::HARD_RESET_MIN_CYCLES);
    hard_reset_input_i = 1'b0;
    cycles(4);
    check({ctrl2_o, watchdog_clear_o}, 9'h080);
    rd(motor_spi_pkg::ADDR_CTRL2);
    check(d, 8'h40);
    wr(motor_spi_pkg::ADDR_CTRL2, 8'h00);
    cycles(6);
    check({sleep_o, analog_enable_o, step_pulse_o, direction_o}, 4'h7);
  endtask
  task automatic t_hard_reset();
    int i;
    wr(motor_spi_pkg::ADDR_CTRL0, 8'h55);
    hard_reset_input_i = 1'b1;
    for (i = 0; i < 20 && watchdog_clear_o !== 1'b1; i++) begin
      @(negedge clock_i);
    end
    if (watchdog_clear_o !== 1'b1) begin
      err_total++;
      give_verdict();
    end
    check(reset_watchdog_output_o, 1'b1);
    // pin held for the least pulse on top of the cycles already waited for the watchdog clear
    cycles(motor_spi_pkg::HARD_RESET_MIN_CYCLES);
    hard_reset_input_i = 1'b0;
    cycles(5);
    check({ctrl_wd_o, ctrl0_o, ctrl1_o, watchdog_clear_o}, 25'h0);
    wr(motor_spi_pkg::ADDR_CTRL1, 8'h21);
    check(ctrl1_o, 8'h21);
  endtask
  ////////////////////////////////////////////////////////////////
  initial begin
    clock_i = 1'b0;
    forever #25 clock_i = ~clock_i;
  end
  initial begin
    err_total = 0;
    n_tests = 0;
    rst_n_i = 1'b0;
    hard_reset_input_i = 1'b0;
    step_i = 1'b0;
    dir_i = 1'b0;
    stat1_evt = 7'h00;
    cycles(6);
    rst_n_i = 1'b1;
    cycles(3);
    t_write_read();
    t_refused();
    t_status();
    t_sleep();
    t_hard_reset();
    give_verdict();
  end
endmodule
